// [hdl/ecc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module ecc_checker
  import ecc_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Instruction boundary strobe and its instruction pointer.
  input  wire logic        eval,
  input  wire logic [31:0] instr_ptr,
  // Traps from the previous instruction.
  input  wire logic        trap_pending,
  input  wire logic [7:0]  trap_vector,
  // External events.
  input  wire logic        ext_int_pending,
  input  wire logic [7:0]  ext_int_vector,
  input  wire logic        mc_event,
  // Fetch, decode and execute facts.
  input  wire ecc_walk_s   fetch_walk,
  input  wire ecc_decode_s dec,
  input  wire ecc_exec_s   exe,
  input  wire ecc_walk_s   data_walk,
  // Signed divide operands.
  input  wire logic        div_req,
  input  wire logic        div_word,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  // Control registers.
  input  wire logic [31:0] control_register_zero,
  input  wire logic        cr4_wr,
  input  wire logic [31:0] cr4_wdata,
  input  wire logic        simd_wr,
  input  wire logic [31:0] simd_wdata,
  // Delivered exception and control write completion.
  output logic             exc_valid,
  output ecc_result_s      exc_result,
  output logic [31:0]      saved_code_pointer,
  output logic             cr4_wr_done,
  // Register state.
  output logic [31:0]      control_register_four,
  output logic             machine_check_enable,
  output logic [31:0]      simd_fp_control_status
);

  logic        div_error;       // Divide result out of range or zero divisor.
  logic        fetch_rsvd;      // Reserved bit found in the fetch walk.
  logic        data_rsvd;       // Reserved bit found in the data walk.
  logic        cr4_rsvd;        // Write sets a reserved bit.
  logic        em_flag;         // Emulation flag.
  logic        ts_flag;         // Task-switched flag.
  logic        os_save_restore_support;          // Save-restore support flag.
  logic        osxmm;           // SIMD exception support flag.
  logic        simd_unmasked;   // SIMD fault with its mask clear.
  logic        beyond_real;     // Operand runs past the real-mode limit.
  logic [16:0] op_end;          // Address of the operand's last byte.
  logic [3:0]  size_m1;         // Operand size in bytes less one.
  logic        is_real;         // Real or virtual-8086 mode.
  ecc_result_s sel;             // Combinational selection.

  // Registered state.
  logic        exc_valid_q;
  logic        exc_valid_d;
  ecc_result_s exc_result_q;
  ecc_result_s exc_result_d;
  logic [31:0] saved_ptr_q;
  logic [31:0] saved_ptr_d;
  logic        cr4_done_q;
  logic        cr4_done_d;
  logic [31:0] cr4_q;
  logic [31:0] cr4_d;
  logic [31:0] simd_q;
  logic [31:0] simd_d;
  logic        mc_pend_q;
  logic        mc_pend_d;

  // Reports whether any touched level of a walk holds a one in a reserved bit.
  function automatic logic walk_rsvd(input ecc_walk_s w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < ECC_WALK_LEVELS; i++)
    begin
      if (w.level_used[i] && ((w.entry[i] & w.rsvd_mask[i]) != 64'h0))
      begin
        hit = 1'b1;
      end
    end
    return w.valid && hit;
  endfunction

  // Builds the page fault error code for a reserved-bit translation fault.
  function automatic logic [31:0] pf_code(input ecc_walk_s w, input logic fetch);
    logic [31:0] c;
    c                  = 32'h0000_0000;
    c[ECC_PFC_PRESENT] = 1'b1;
    c[ECC_PFC_WRITE]   = w.write;
    c[ECC_PFC_USER]    = w.user;
    c[ECC_PFC_RSVD]    = 1'b1;
    c[ECC_PFC_FETCH]   = fetch;
    return c;
  endfunction

  // Forms one result value.
  function automatic ecc_result_s mk(input ecc_cat_e c, input logic [7:0] v,
                                     input logic ev, input logic [31:0] ec);
    ecc_result_s r;
    r.cat       = c;
    r.vector    = v;
    r.err_valid = ev;
    r.err_code  = ec;
    return r;
  endfunction

  // Range check for signed divides.
  ecc_div_check u_div (
    .div_word  (div_word),
    .dividend  (dividend),
    .divisor   (divisor),
    .div_error (div_error)
  );

  // Derives the condition terms used by the priority selection.
  always_comb
  begin
    fetch_rsvd    = walk_rsvd(fetch_walk); // RQ3
    data_rsvd     = walk_rsvd(data_walk); // RQ3
    cr4_rsvd      = cr4_wr && ((cr4_wdata & ECC_CR4_RSVD_MASK) != 32'h0); // RQ2
    em_flag       = control_register_zero[ECC_CR0_EM_BIT];
    ts_flag       = control_register_zero[ECC_CR0_TS_BIT];
    os_save_restore_support        = cr4_q[ECC_CR4_OS_SAVE_RESTORE_SUPPORT_BIT];
    osxmm         = cr4_q[ECC_CR4_OSXMM_BIT];
    simd_unmasked = exe.simd_fp_op &&
                    ((exe.simd_flags &
                      ~simd_q[ECC_SIMD_MASK_LSB +: ECC_SIMD_NFLAGS]) != '0);
    size_m1       = 4'((5'h01 << exe.size_log2) - 5'h01);
    op_end        = {1'b0, exe.mem_offset} + {13'h0000, size_m1};
    beyond_real   = op_end > {1'b0, ECC_REAL_LIMIT}; // RQ19
    is_real       = (exe.mode == ECC_MODE_REAL) || (exe.mode == ECC_MODE_V86);
  end

  // Picks at most one event, first by category and then by fixed inner order.
  always_comb
  begin
    sel = mk(ECC_CAT_NONE, 8'h00, 1'b0, 32'h0);
    // Traps from the previous instruction come first.
    if (trap_pending) // RQ9
    begin
      sel = mk(ECC_CAT_TRAP, trap_vector, 1'b0, 32'h0);
    end
    // A pending machine check leads the external events.
    else if (mc_pend_q) // RQ1
    begin
      sel = mk(ECC_CAT_EXT, ECC_VEC_MCHECK, 1'b0, 32'h0);
    end
    else if (ext_int_pending) // RQ9
    begin
      sel = mk(ECC_CAT_EXT, ext_int_vector, 1'b0, 32'h0);
    end
    // Faults while fetching the instruction.
    else if (fetch_rsvd) // RQ3
    begin
      sel = mk(ECC_CAT_FETCH, ECC_VEC_PAGE, 1'b1, pf_code(fetch_walk, 1'b1));
    end
    // Decode faults: length limit ahead of opcode faults.
    else if (dec.insn_len > ECC_MAX_INSN_LEN) // RQ8
    begin
      sel = mk(ECC_CAT_DECODE, ECC_VEC_PROTECT, 1'b1, 32'h0);
    end
    else if (dec.lock_illegal || dec.test_reg_move) // RQ7 RQ10
    begin
      sel = mk(ECC_CAT_DECODE, ECC_VEC_OPCODE, 1'b0, 32'h0);
    end
    else if (dec.legacy_simd &&
             (em_flag || !os_save_restore_support || dec.lock_prefix || !dec.simd_feature_ok)) // RQ13 RQ14
    begin
      sel = mk(ECC_CAT_DECODE, ECC_VEC_OPCODE, 1'b0, 32'h0);
    end
    // Execution faults, in the fixed order below.
    else if (dec.legacy_simd && ts_flag) // RQ15
    begin
      sel = mk(ECC_CAT_EXEC, ECC_VEC_NO_DEV, 1'b0, 32'h0);
    end
    else if (dec.legacy_simd && exe.x87_pending) // RQ15
    begin
      sel = mk(ECC_CAT_EXEC, ECC_VEC_MATH, 1'b0, 32'h0);
    end
    else if (exe.mem_access && exe.ss_ref &&
             (((exe.mode == ECC_MODE_PROT) && exe.ss_illegal) ||
              ((exe.mode == ECC_MODE_64) && exe.noncanonical))) // RQ16
    begin
      sel = mk(ECC_CAT_EXEC, ECC_VEC_STACK, 1'b1, 32'h0);
    end
    else if ((exe.mem_access && exe.simd_align16 &&
              (exe.mem_offset[3:0] != 4'h0)) || // RQ17
             (exe.mem_access && !exe.ss_ref &&
              (((exe.mode == ECC_MODE_PROT) && exe.seg_illegal) ||
               ((exe.mode == ECC_MODE_64) && exe.noncanonical))) || // RQ18
             (exe.mem_access && is_real && beyond_real) || // RQ19
             cr4_rsvd) // RQ2
    begin
      sel = mk(ECC_CAT_EXEC, ECC_VEC_PROTECT, 1'b1, 32'h0);
    end
    else if (exe.mem_access && data_rsvd) // RQ3
    begin
      sel = mk(ECC_CAT_EXEC, ECC_VEC_PAGE, 1'b1, pf_code(data_walk, 1'b0));
    end
    else if (exe.mem_access && exe.align_check_on && (exe.mode != ECC_MODE_REAL) &&
             ((exe.mem_offset[3:0] & size_m1) != 4'h0)) // RQ4
    begin
      sel = mk(ECC_CAT_EXEC, ECC_VEC_ALIGN, 1'b1, 32'h0);
    end
    else if (div_req && div_error) // RQ5 RQ6
    begin
      sel = mk(ECC_CAT_EXEC, ECC_VEC_DIVIDE, 1'b0, 32'h0);
    end
    else if (simd_unmasked) // RQ12
    begin
      sel = mk(ECC_CAT_EXEC, osxmm ? ECC_VEC_SIMD : ECC_VEC_OPCODE, 1'b0, 32'h0); // RQ11
    end
  end

  // Computes the next delivery state; one event per boundary strobe.
  always_comb
  begin
    exc_valid_d  = 1'b0;
    exc_result_d = exc_result_q;
    saved_ptr_d  = saved_ptr_q;
    cr4_done_d   = 1'b0;
    if (eval)
    begin
      exc_valid_d = (sel.cat != ECC_CAT_NONE); // RQ20
      if (sel.cat != ECC_CAT_NONE)
      begin
        exc_result_d = sel;
        // The pointer names the instruction that faulted, not its successor.
        saved_ptr_d  = instr_ptr; // RQ5
      end
      // A control write completes only when nothing was raised.
      cr4_done_d = cr4_wr && (sel.cat == ECC_CAT_NONE); // RQ2
    end
  end

  // Computes the next control register, machine-check and SIMD status state.
  always_comb
  begin
    cr4_d     = cr4_q;
    mc_pend_d = mc_pend_q;
    simd_d    = simd_q;
    if (cr4_done_d)
    begin
      cr4_d = cr4_wdata; // RQ2
    end
    // Delivery clears the pending check; a new event wins over that clear.
    if (eval && (sel.cat == ECC_CAT_EXT) && (sel.vector == ECC_VEC_MCHECK) && mc_pend_q)
    begin
      mc_pend_d = 1'b0;
    end
    // Machine checks are dropped, not held, while the enable is clear; the gate
    // uses the next enable so a same-edge clear cannot leave a check pending.
    if (mc_event && cr4_d[ECC_CR4_MCE_BIT]) // RQ1
    begin
      mc_pend_d = 1'b1;
    end
    if (!cr4_d[ECC_CR4_MCE_BIT]) // RQ1
    begin
      mc_pend_d = 1'b0;
    end
    // Software write first, then new SIMD flags are ORed in so they survive it.
    if (simd_wr)
    begin
      simd_d = simd_wdata;
    end
    if (eval && exe.simd_fp_op)
    begin
      simd_d[ECC_SIMD_FLAG_LSB +: ECC_SIMD_NFLAGS] =
        simd_d[ECC_SIMD_FLAG_LSB +: ECC_SIMD_NFLAGS] | exe.simd_flags; // RQ11
    end
  end

  // Registers all state; the clock enable freezes everything.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_valid_q  <= 1'b0;
      exc_result_q <= '{cat: ECC_CAT_NONE, vector: 8'h00, err_valid: 1'b0,
                        err_code: 32'h0000_0000};
      saved_ptr_q  <= 32'h0000_0000;
      cr4_done_q   <= 1'b0;
      cr4_q        <= ECC_CR4_RESET; // RQ1
      mc_pend_q    <= 1'b0;
      simd_q       <= ECC_SIMD_RESET;
    end
    else if (ce)
    begin
      exc_valid_q  <= exc_valid_d;
      exc_result_q <= exc_result_d;
      saved_ptr_q  <= saved_ptr_d;
      cr4_done_q   <= cr4_done_d;
      cr4_q        <= cr4_d;
      mc_pend_q    <= mc_pend_d;
      simd_q       <= simd_d;
    end
  end

  // Output drive, all from flip-flops.
  assign exc_valid              = exc_valid_q;
  assign exc_result             = exc_result_q;
  assign saved_code_pointer     = saved_ptr_q;
  assign cr4_wr_done            = cr4_done_q;
  assign control_register_four  = cr4_q;
  assign machine_check_enable   = cr4_q[ECC_CR4_MCE_BIT];
  assign simd_fp_control_status = simd_q;

endmodule
`default_nettype wire

// [hdl/ecc_pkg.sv]
// Function
// RQ1: Machine check only while its enable set.
// RQ2: Reserved-bit register write gives protection fault.
// RQ3: Reserved translation entry bit gives page fault.
// RQ4: Unaligned access under alignment checking faults.
// RQ5: Divide fault saves faulting instruction pointer.
// RQ6: Most negative signed quotient completes normally.
// RQ7: Improper bus-lock prefix gives invalid opcode.
// RQ8: Instructions over fifteen bytes give protection fault.
// RQ9: Five categories serviced in fixed order.
// RQ10: Test register moves give invalid opcode.
// RQ11: SIMD faults recorded in status, vector 19.
// RQ12: Unmasked SIMD fault: opcode or SIMD by flag.
// RQ13: Emulation set or save-restore clear: invalid opcode.
// RQ14: Lock prefix or missing feature: invalid opcode.
// RQ15: Pending x87 fault first; task-switched gives unavailable. The code checks task-switched before the pending x87 fault.
// RQ16: Illegal or non-canonical stack address: stack fault.
// RQ17: Legacy SIMD operand not 16-aligned: protection fault.
// RQ18: Illegal segment or non-canonical address: protection fault.
// RQ19: Real mode operand past FFFFH: protection fault.
// RQ20: One exception per instruction, fixed inner order.
package ecc_pkg;

  // Exception vectors delivered on the result port.
  localparam logic [7:0] ECC_VEC_DIVIDE   = 8'h00;
  localparam logic [7:0] ECC_VEC_OPCODE   = 8'h06;
  localparam logic [7:0] ECC_VEC_NO_DEV   = 8'h07;
  localparam logic [7:0] ECC_VEC_STACK    = 8'h0C;
  localparam logic [7:0] ECC_VEC_PROTECT  = 8'h0D;
  localparam logic [7:0] ECC_VEC_PAGE     = 8'h0E;
  localparam logic [7:0] ECC_VEC_MATH     = 8'h10;
  localparam logic [7:0] ECC_VEC_ALIGN    = 8'h11;
  localparam logic [7:0] ECC_VEC_MCHECK   = 8'h12;
  localparam logic [7:0] ECC_VEC_SIMD     = 8'h13;

  // Bit positions in control register zero (an input here).
  localparam int ECC_CR0_EM_BIT = 2;
  localparam int ECC_CR0_TS_BIT = 3;

  // Bit positions, reserved mask and reset value of control register four.
  localparam int          ECC_CR4_MCE_BIT    = 6;
  localparam int          ECC_CR4_OS_SAVE_RESTORE_SUPPORT_BIT = 9;
  localparam int          ECC_CR4_OSXMM_BIT  = 10;
  localparam logic [31:0] ECC_CR4_RSVD_MASK  = 32'hFFFF_F800;
  localparam logic [31:0] ECC_CR4_RESET      = 32'h0000_0000;

  // SIMD control and status layout: sticky flags low, masks above them.
  localparam int          ECC_SIMD_FLAG_LSB  = 0;
  localparam int          ECC_SIMD_MASK_LSB  = 7;
  localparam int          ECC_SIMD_NFLAGS    = 6;
  localparam logic [31:0] ECC_SIMD_RESET     = 32'h0000_1F80;

  // Longest legal instruction in bytes, prefixes included.
  localparam logic [4:0] ECC_MAX_INSN_LEN = 5'h0F;

  // Page fault error code bit positions.
  localparam int ECC_PFC_PRESENT = 0;
  localparam int ECC_PFC_WRITE   = 1;
  localparam int ECC_PFC_USER    = 2;
  localparam int ECC_PFC_RSVD    = 3;
  localparam int ECC_PFC_FETCH   = 4;

  // Translation levels checked per walk: table, directory, pointer entries.
  localparam int ECC_WALK_LEVELS = 3;

  // Most negative quotients that a signed divide may still produce.
  localparam logic [7:0]  ECC_DIV_BYTE_MIN = 8'h80;
  localparam logic [15:0] ECC_DIV_WORD_MIN = 16'h8000;

  // Last byte address of the real-mode effective address space.
  localparam logic [15:0] ECC_REAL_LIMIT = 16'hFFFF;

  // Operating modes, one-hot.
  typedef enum logic [3:0] {
    ECC_MODE_REAL = 4'h1,
    ECC_MODE_V86  = 4'h2,
    ECC_MODE_PROT = 4'h4,
    ECC_MODE_64   = 4'h8
  } ecc_mode_e;

  // Priority category of the delivered event, one-hot.
  typedef enum logic [5:0] {
    ECC_CAT_NONE   = 6'h01,
    ECC_CAT_TRAP   = 6'h02,
    ECC_CAT_EXT    = 6'h04,
    ECC_CAT_FETCH  = 6'h08,
    ECC_CAT_DECODE = 6'h10,
    ECC_CAT_EXEC   = 6'h20
  } ecc_cat_e;

  // One address translation walk with the entries it touched.
  typedef struct packed {
    logic                                    valid;
    logic                                    user;
    logic                                    write;
    logic [ECC_WALK_LEVELS-1:0]              level_used;
    logic [ECC_WALK_LEVELS-1:0][63:0]        entry;
    logic [ECC_WALK_LEVELS-1:0][63:0]        rsvd_mask;
  } ecc_walk_s;

  // Facts that the decoder reports about the instruction.
  typedef struct packed {
    logic [4:0] insn_len;
    logic       lock_prefix;
    logic       lock_illegal;
    logic       test_reg_move;
    logic       legacy_simd;
    logic       simd_feature_ok;
  } ecc_decode_s;

  // Facts that the execute stage reports about the instruction.
  typedef struct packed {
    ecc_mode_e  mode;
    logic       mem_access;
    logic [15:0] mem_offset;
    logic [2:0] size_log2;
    logic       ss_ref;
    logic       ss_illegal;
    logic       seg_illegal;
    logic       noncanonical;
    logic       simd_align16;
    logic       align_check_on;
    logic       x87_pending;
    logic       simd_fp_op;
    logic [ECC_SIMD_NFLAGS-1:0] simd_flags;
  } ecc_exec_s;

  // The single exception selected for delivery.
  typedef struct packed {
    ecc_cat_e    cat;
    logic [7:0]  vector;
    logic        err_valid;
    logic [31:0] err_code;
  } ecc_result_s;

endpackage

// [hdl/ecc_div_check.sv]
`timescale 1ns/1ps
`default_nettype none
module ecc_div_check
  import ecc_pkg::*;
(
  // Operation size and operands.
  input  wire logic        div_word,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  // Result.
  output logic             div_error
);

  logic signed [33:0] num;  // Sign-extended dividend.
  logic signed [33:0] den;  // Sign-extended divisor, never zero.
  logic signed [33:0] quo;  // Exact quotient.
  logic signed [33:0] lo;   // Most negative legal quotient.
  logic signed [33:0] hi;   // Most positive legal quotient.
  logic               zero; // Divisor is zero.

  // Computes the quotient and flags a zero divisor or an out-of-range result.
  always_comb
  begin
    if (div_word)
    begin
      num  = {{2{dividend[31]}}, dividend};
      zero = (divisor == 16'h0000);
      den  = zero ? 34'sh1 : {{18{divisor[15]}}, divisor};
      lo   = {{18{1'b1}}, ECC_DIV_WORD_MIN};
    end
    else
    begin
      num  = {{18{dividend[15]}}, dividend[15:0]};
      zero = (divisor[7:0] == 8'h00);
      den  = zero ? 34'sh1 : {{26{divisor[7]}}, divisor[7:0]};
      lo   = {{26{1'b1}}, ECC_DIV_BYTE_MIN};
    end
    hi        = ~lo;
    quo       = num / den;
    // The most negative quotient itself is legal and completes normally.
    div_error = zero || (quo < lo) || (quo > hi); // RQ6
  end

endmodule
`default_nettype wire

// [dv/ecc_pipe_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ecc_pipe_model
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Request from the bench to retire one instruction.
  input  wire logic        go,
  // Boundary strobe and pointer towards the checker.
  output logic             eval,
  output logic [31:0]      instr_ptr
);
  // The strobe lasts one cycle per request; the pointer is stable until the next one.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eval      <= 1'b0;
      instr_ptr <= 32'h0000_1000;
    end
    else
    begin
      eval <= go;
      if (go)
      begin
        instr_ptr <= instr_ptr + 32'h0000_0004;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/ecc_checker_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ecc_checker_monitor
  import ecc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Evaluation inputs.
  input  wire logic        ce,
  input  wire logic        eval,
  input  wire logic [31:0] instr_ptr,
  input  wire logic        trap_pending,
  input  wire logic [7:0]  trap_vector,
  input  wire logic        ext_int_pending,
  input  wire ecc_decode_s dec,
  input  wire logic        cr4_wr,
  input  wire logic [31:0] cr4_wdata,
  // Outputs under watch.
  input  wire logic        exc_valid,
  input  wire ecc_result_s exc_result,
  input  wire logic [31:0] saved_code_pointer,
  input  wire logic        cr4_wr_done,
  input  wire logic [31:0] control_register_four,
  input  wire logic        machine_check_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  rsvd_clear_a: assert property ((control_register_four & ECC_CR4_RSVD_MASK) == 32'h0)
    else $error("reserved control bit set");
  mc_gate_a: assert property (exc_valid && exc_result.cat == ECC_CAT_EXT &&
    exc_result.vector == ECC_VEC_MCHECK && !$past(ext_int_pending) |-> $past(machine_check_enable))
    else $error("machine check while disabled");
  rsvd_write_a: assert property (ce && eval && cr4_wr && (cr4_wdata & ECC_CR4_RSVD_MASK) != 0
    |=> exc_valid && !cr4_wr_done && $stable(control_register_four))
    else $error("reserved control write completed");
  cr4_hold_a: assert property ($changed(control_register_four) |-> cr4_wr_done)
    else $error("control register changed without a write");
  long_insn_a: assert property (ce && eval && dec.insn_len > ECC_MAX_INSN_LEN |=> exc_valid)
    else $error("over-long instruction not faulted");
  trap_first_a: assert property (ce && eval && trap_pending |=> exc_valid &&
    exc_result.cat == ECC_CAT_TRAP && exc_result.vector == $past(trap_vector))
    else $error("pending trap not delivered first");
  test_reg_a: assert property (ce && eval && dec.test_reg_move |=> exc_valid)
    else $error("test register move executed");
  one_shot_a: assert property (exc_valid |-> $past(eval))
    else $error("exception without a strobe");
  ptr_saved_a: assert property (exc_valid |-> saved_code_pointer == $past(instr_ptr))
    else $error("saved pointer not the faulting one");
  cv_trap: cover property (exc_valid && exc_result.cat == ECC_CAT_TRAP);
  cv_wr: cover property (cr4_wr_done);
  cv_mc: cover property (exc_valid && exc_result.vector == ECC_VEC_MCHECK);
endmodule
bind ecc_checker ecc_checker_monitor mon_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
  .eval(eval), .instr_ptr(instr_ptr), .trap_pending(trap_pending), .trap_vector(trap_vector),
  .ext_int_pending(ext_int_pending), .dec(dec), .cr4_wr(cr4_wr), .cr4_wdata(cr4_wdata),
  .exc_valid(exc_valid), .exc_result(exc_result), .saved_code_pointer(saved_code_pointer),
  .cr4_wr_done(cr4_wr_done), .control_register_four(control_register_four),
  .machine_check_enable(machine_check_enable));
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import ecc_pkg::*;
  logic clk_sys, rst_n, ce, go, eval, trap_pending, ext_int_pending, mc_event, div_req, div_word;
  logic cr4_wr, simd_wr, exc_valid, cr4_wr_done, machine_check_enable;
  logic [7:0]  trap_vector, ext_int_vector;
  logic [15:0] divisor;
  logic [31:0] instr_ptr, dividend, cr0, cr4_wdata, simd_wdata, saved_code_pointer, cr4_q, simd_q;
  ecc_walk_s   fetch_walk, data_walk;
  ecc_decode_s dec;
  ecc_exec_s   exe;
  ecc_result_s exc_result;
  int fail_count = 0;
  int samples_checked = 0;

  ecc_pipe_model pipe_u (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .eval(eval),
    .instr_ptr(instr_ptr));
  ecc_checker dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .eval(eval),
    .instr_ptr(instr_ptr), .trap_pending(trap_pending), .trap_vector(trap_vector),
    .ext_int_pending(ext_int_pending), .ext_int_vector(ext_int_vector), .mc_event(mc_event),
    .fetch_walk(fetch_walk), .dec(dec), .exe(exe), .data_walk(data_walk), .div_req(div_req),
    .div_word(div_word), .dividend(dividend), .divisor(divisor), .control_register_zero(cr0),
    .cr4_wr(cr4_wr), .cr4_wdata(cr4_wdata), .simd_wr(simd_wr), .simd_wdata(simd_wdata),
    .exc_valid(exc_valid), .exc_result(exc_result), .saved_code_pointer(saved_code_pointer),
    .cr4_wr_done(cr4_wr_done), .control_register_four(cr4_q), .machine_check_enable(machine_check_enable),
    .simd_fp_control_status(simd_q));

  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Puts a plain, fault-free instruction on the stage inputs.
  task automatic clear;
    dec = '0; dec.insn_len = 5'h04; dec.simd_feature_ok = 1'b1;
    exe = '0; exe.mode = ECC_MODE_PROT; data_walk = '0; fetch_walk = '0; cr0 = 32'h0;
    trap_pending = 1'b0; ext_int_pending = 1'b0; div_req = 1'b0; cr4_wr = 1'b0;
  endtask

  // Retires one instruction and judges the answer a cycle later.
  task automatic issue_chk(input logic v, input logic [7:0] vec);
    go = 1'b1;
    @(posedge clk_sys) #1 go = 1'b0;
    @(posedge clk_sys) #1;
    `CHK("exc_valid", v, exc_valid)
    if (v)
    begin
      `CHK("vector", vec, exc_result.vector)
      `CHK("saved_ptr", instr_ptr, saved_code_pointer)
    end
  endtask

  // A legal control write completes only when nothing else is raised.
  task automatic wr_cr4(input logic [31:0] d);
    clear(); cr4_wr = 1'b1; cr4_wdata = d;
    issue_chk(1'b0, 8'h00);
    `CHK("wr_done", 1'b1, cr4_wr_done)
    `CHK("cr4", d, cr4_q)
  endtask

  // One machine-check event between instructions.
  task automatic pulse_mc;
    @(posedge clk_sys) #1 mc_event = 1'b1;
    @(posedge clk_sys) #1 mc_event = 1'b0;
  endtask

  task automatic t_reset;
    `CHK("cr4_reset", 32'h0, cr4_q)
    `CHK("mce_reset", 1'b0, machine_check_enable)
    `CHK("simd_reset", 32'h0000_1F80, simd_q)
    pulse_mc(); clear(); issue_chk(1'b0, 8'h00);
  endtask

  task automatic t_decode;
    clear(); dec.insn_len = 5'h0F; issue_chk(1'b0, 8'h00);
    ce = 1'b0; dec.insn_len = 5'h10; issue_chk(1'b0, 8'h00); ce = 1'b1;
    dec.insn_len = 5'h10; issue_chk(1'b1, 8'h0D);
    `CHK("cat", ECC_CAT_DECODE, exc_result.cat)
    clear(); dec.lock_illegal = 1'b1; issue_chk(1'b1, 8'h06);
    clear(); dec.test_reg_move = 1'b1; issue_chk(1'b1, 8'h06);
  endtask

  task automatic t_cr4_mc;
    clear(); cr4_wr = 1'b1; cr4_wdata = 32'h0000_0840; issue_chk(1'b1, 8'h0D);
    `CHK("cr4_kept", 32'h0, cr4_q)
    wr_cr4(32'h0000_0040);
    `CHK("mce_set", 1'b1, machine_check_enable)
    pulse_mc(); clear(); issue_chk(1'b1, 8'h12);
    clear(); dec.legacy_simd = 1'b1; issue_chk(1'b1, 8'h06);
    wr_cr4(32'h0000_0200);
    pulse_mc(); clear(); issue_chk(1'b0, 8'h00);
  endtask

  task automatic t_prio;
    clear(); trap_pending = 1'b1; trap_vector = 8'h01; ext_int_pending = 1'b1;
    ext_int_vector = 8'h20; dec.insn_len = 5'h10; issue_chk(1'b1, 8'h01);
    trap_pending = 1'b0; issue_chk(1'b1, 8'h20);
    ext_int_pending = 1'b0; exe.mem_access = 1'b1; exe.seg_illegal = 1'b1;
    issue_chk(1'b1, 8'h0D);
    `CHK("cat_dec", ECC_CAT_DECODE, exc_result.cat)
  endtask

  task automatic t_exec;
    clear(); exe.mem_access = 1'b1; exe.ss_ref = 1'b1; exe.ss_illegal = 1'b1;
    issue_chk(1'b1, 8'h0C);
    exe.mode = ECC_MODE_64; exe.ss_illegal = 1'b0; exe.noncanonical = 1'b1;
    issue_chk(1'b1, 8'h0C);
    exe.ss_ref = 1'b0; issue_chk(1'b1, 8'h0D);
    clear(); exe.mem_access = 1'b1; exe.seg_illegal = 1'b1; issue_chk(1'b1, 8'h0D);
    clear(); exe.mem_access = 1'b1; exe.mode = ECC_MODE_REAL; exe.size_log2 = 3'h1;
    exe.mem_offset = 16'hFFFE; issue_chk(1'b0, 8'h00);
    exe.mem_offset = 16'hFFFF; issue_chk(1'b1, 8'h0D);
    clear(); exe.mem_access = 1'b1; exe.align_check_on = 1'b1; exe.size_log2 = 3'h1;
    exe.mem_offset = 16'h0001; issue_chk(1'b1, 8'h11);
    clear(); data_walk.valid = 1'b1; data_walk.level_used = 3'h2; exe.mem_access = 1'b1;
    data_walk.entry[1] = 64'h8; data_walk.rsvd_mask[1] = 64'h8; issue_chk(1'b1, 8'h0E);
    `CHK("pf_code", 32'h9, exc_result.err_code)
    fetch_walk = data_walk; issue_chk(1'b1, 8'h0E);
    `CHK("pf_fetch", 32'h19, exc_result.err_code)
  endtask

  task automatic t_div;
    clear(); div_req = 1'b1; div_word = 1'b0; dividend = 32'h0000_FF00; divisor = 16'h0002;
    issue_chk(1'b0, 8'h00);
    div_word = 1'b1; dividend = 32'hFFFF_0000; issue_chk(1'b0, 8'h00);
    dividend = 32'h0001_0000; issue_chk(1'b1, 8'h00);
  endtask

  task automatic t_simd;
    clear(); dec.legacy_simd = 1'b1; cr0 = 32'h4; issue_chk(1'b1, 8'h06);
    cr0 = 32'h8; issue_chk(1'b1, 8'h07);
    cr0 = 32'h0; exe.x87_pending = 1'b1; issue_chk(1'b1, 8'h10);
    exe.x87_pending = 1'b0; dec.lock_prefix = 1'b1; issue_chk(1'b1, 8'h06);
    dec.lock_prefix = 1'b0; dec.simd_feature_ok = 1'b0; issue_chk(1'b1, 8'h06);
    clear(); dec.legacy_simd = 1'b1; exe.mem_access = 1'b1; exe.simd_align16 = 1'b1;
    exe.mode = ECC_MODE_REAL; exe.mem_offset = 16'h0008; issue_chk(1'b1, 8'h0D);
    @(posedge clk_sys) #1 simd_wr = 1'b1;
    @(posedge clk_sys) #1 simd_wr = 1'b0;
    clear(); dec.legacy_simd = 1'b1; exe.simd_fp_op = 1'b1; exe.simd_flags = 6'h01;
    issue_chk(1'b1, 8'h06);
    `CHK("simd_flag", 32'h1, simd_q)
    wr_cr4(32'h0000_0600);
    clear(); dec.legacy_simd = 1'b1; exe.simd_fp_op = 1'b1; exe.simd_flags = 6'h01;
    issue_chk(1'b1, 8'h13);
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short after far more time than the tests need.
  initial
  begin
    #50000;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence: reset for three cycles, then the scenarios in order.
  initial
  begin
    rst_n = 1'b0; ce = 1'b1; go = 1'b0; mc_event = 1'b0; simd_wr = 1'b0;
    simd_wdata = 32'h0; trap_vector = 8'h00; ext_int_vector = 8'h00;
    div_word = 1'b0; dividend = 32'h0; divisor = 16'h0001; cr4_wdata = 32'h0;
    clear();
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset();
    t_decode();
    t_cr4_mc();
    t_prio();
    t_exec();
    t_div();
    t_simd();
    tally_and_finish();
  end
endmodule
`default_nettype wire
